// file: logic/fpv_pkg.sv
/*
 Package for the flash protect/verify controller: register offsets, field
 positions, reset values, timing constants, modes and carried structs.
 Assumes an APB master with 32-bit data and word-aligned registers.
*/
package fpv_pkg;
   // Register byte offsets
   localparam logic [7:0] FPV_OFS_CTRL = 8'h00;
   localparam logic [7:0] FPV_OFS_BLK1 = 8'h04;
   localparam logic [7:0] FPV_OFS_BLK2 = 8'h08;
   localparam logic [7:0] FPV_OFS_WAIT = 8'h0C;
   localparam logic [7:0] FPV_OFS_COND = 8'h10;
   localparam logic [7:0] FPV_OFS_STAT = 8'h14;
   // flash_ctrl_reg fields
   localparam int FPV_BIT_WRARM = 0;
   localparam int FPV_BIT_SCARM = 1;
   localparam int FPV_BIT_WRCHK = 2;
   localparam int FPV_BIT_SCCHK = 3;
   // wait_ctrl_reg fields
   localparam int FPV_BIT_OVLO = 6;
   localparam int FPV_BIT_OVHI = 7;
   // cond_flags_reg field
   localparam int FPV_BIT_MASK = 7;
   // Reset values
   localparam logic [7:0] FPV_RST_CTRL = 8'h00;
   localparam logic [7:0] FPV_RST_BLK1 = 8'h00;
   localparam logic [7:0] FPV_RST_BLK2 = 8'h00;
   localparam logic [7:0] FPV_RST_WAIT = 8'h08;
   localparam logic [7:0] FPV_RST_COND = 8'h00;
   localparam logic [7:0] FPV_BOOT_WAIT = 8'hC8;
   localparam logic [7:0] FPV_BOOT_COND = 8'h80;
   // Block select: upper nibble of register 1 is stored and read back but selects no block
   localparam logic [7:0] FPV_BLK1_MASK = 8'h0F;
   // Overlay windows
   localparam logic [15:0] FPV_RAM_WIN_BASE = 16'hFC00;
   localparam logic [15:0] FPV_ROM_WIN_END = 16'h007F;
   // Timing
   localparam int FPV_CLK_MHZ = 100;
   localparam int FPV_TVS_US = 4;
   localparam int FPV_TVS_CYC = FPV_TVS_US * FPV_CLK_MHZ;
   localparam int FPV_TVS_W = 9;
   localparam int FPV_RST_MIN_CYC = 10;

   typedef enum logic [4:0]
   {
      FPV_MODE_IDLE = 5'b00001,
      FPV_MODE_PROG = 5'b00010,
      FPV_MODE_ERASE = 5'b00100,
      FPV_MODE_VERIFY = 5'b01000,
      FPV_MODE_PREVF = 5'b10000
   } fpv_mode_type;

   typedef struct packed
   {
      logic prog_en;
      logic erase_en;
      logic verify_en;
      logic prevf_en;
      logic prevf_ready;
      logic read_unreliable;
      logic [11:0] blk_en;
   } fpv_flash_ctl_type;

   typedef struct packed
   {
      logic overlay_on;
      logic [1:0] overlay_sel;
      logic irq_masked;
      logic irq_latched;
   } fpv_ovl_type;
endpackage

// file: logic/fpv_flash_protect_verify_ctrl.sv
/*
 Flash protect/verify controller: control registers over APB, verify mode
 selection, software and hardware protection gating of program and erase,
 interrupt abort latch and RAM overlay of the vector area.
 Assumes hv_supply_pin, standby and interrupt inputs are asynchronous pins
 and that APB is on mclk.
*/
`timescale 1ns/1ns
module fpv_flash_protect_verify_ctrl
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wdt_rst,
   input wire logic standby_pin,
   input wire logic hv_supply_pin,
   input wire logic boot_mode,
   input wire logic irq_pin,
   input wire logic nmi_pin,
   input wire logic [15:0] cpu_addr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output fpv_pkg::fpv_flash_ctl_type flash_ctl,
   output fpv_pkg::fpv_ovl_type ovl,
   output logic [15:0] mapped_addr,
   output logic irq_to_cpu,
   output logic nmi_to_cpu
);
   import fpv_pkg::*;

   logic [1:0] rst_sync_r;
   logic rst_int_n;
   logic [1:0] hv_sync_r;
   logic [1:0] stby_sync_r;
   logic [1:0] irq_sync_r;
   logic [1:0] nmi_sync_r;
   logic hv_ok;
   logic stby;
   logic irq_s;
   logic nmi_s;
   logic clr_regs;
   logic [7:0] ctrl_r;
   logic [7:0] blk1_r;
   logic [7:0] blk2_r;
   logic [7:0] wait_r;
   logic [7:0] cond_r;
   logic abort_r;
   logic boot_done_r;
   logic [FPV_TVS_W-1:0] tvs_cnt_r;
   logic [FPV_TVS_W-1:0] tvs_cnt_nxt;
   logic [31:0] prdata_nxt;
   logic wr_en;
   logic rd_en;
   logic hit;
   logic emu_protect;
   logic sw_blocked;
   logic any_arm;
   logic irq_eff;
   logic ovl_on;
   logic [11:0] blk_all;
   fpv_mode_type mode;

   // Reset release through two flops
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_r <= 2'b00;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_int_n = rst_sync_r[1];

   // Pin synchronisers
   always_ff @(posedge mclk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         hv_sync_r <= 2'b00;
         stby_sync_r <= 2'b00;
         irq_sync_r <= 2'b00;
         nmi_sync_r <= 2'b00;
      end
      else
      begin
         hv_sync_r <= {hv_sync_r[0], hv_supply_pin};
         stby_sync_r <= {stby_sync_r[0], standby_pin};
         irq_sync_r <= {irq_sync_r[0], irq_pin};
         nmi_sync_r <= {nmi_sync_r[0], nmi_pin};
      end
   end
   assign hv_ok = hv_sync_r[1];
   assign stby = stby_sync_r[1];
   assign irq_s = irq_sync_r[1];
   assign nmi_s = nmi_sync_r[1];

   // Hardware protection clear: no 12 V, watchdog or standby
   assign clr_regs = !hv_ok || wdt_rst || stby;

   // APB decode; zero wait states
   assign hit = (paddr == FPV_OFS_CTRL) || (paddr == FPV_OFS_BLK1) || (paddr == FPV_OFS_BLK2) ||
                (paddr == FPV_OFS_WAIT) || (paddr == FPV_OFS_COND) || (paddr == FPV_OFS_STAT);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !hit;
   assign wr_en = psel && penable && pwrite && pstrb[0] && hit;
   assign rd_en = psel && !penable && !pwrite;

   // Flash control and block select registers
   always_ff @(posedge mclk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         ctrl_r <= FPV_RST_CTRL;
         blk1_r <= FPV_RST_BLK1;
         blk2_r <= FPV_RST_BLK2;
      end
      else if (clr_regs)
      begin
         ctrl_r <= FPV_RST_CTRL;
         blk1_r <= FPV_RST_BLK1;
         blk2_r <= FPV_RST_BLK2;
      end
      else if (wr_en)
      begin
         if (paddr == FPV_OFS_CTRL)
            ctrl_r <= {4'h0, pwdata[3:0]};
         if (paddr == FPV_OFS_BLK1)
            blk1_r <= pwdata[7:0];
         if (paddr == FPV_OFS_BLK2)
            blk2_r <= pwdata[7:0];
      end
   end

   // Wait and condition registers; boot leaves both overlay bits and the mask set
   always_ff @(posedge mclk or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         wait_r <= FPV_RST_WAIT;
         cond_r <= FPV_RST_COND;
         boot_done_r <= 1'b0;
      end
      else if (!boot_done_r)
      begin
         boot_done_r <= 1'b1;
         if (boot_mode)
         begin
            wait_r <= FPV_BOOT_WAIT;
            cond_r <= FPV_BOOT_COND;
         end
      end
      else if (wr_en)
      begin
         if (paddr == FPV_OFS_WAIT)
            wait_r <= pwdata[7:0];
         if (paddr == FPV_OFS_COND)
            cond_r <= pwdata[7:0];
      end
   end

   // Interrupt masking: mask flag leaves only the non-maskable path
   assign irq_eff = irq_s && !cond_r[FPV_BIT_MASK];
   assign irq_to_cpu = irq_eff;
   assign nmi_to_cpu = nmi_s;

   // Abort latch; only reset clears it, set wins over every write
   always_ff @(posedge mclk or negedge rst_int_n)
   begin
      if (!rst_int_n)
         abort_r <= 1'b0;
      else if ((irq_eff || nmi_s) && (ctrl_r[FPV_BIT_WRARM] || ctrl_r[FPV_BIT_SCARM]))
         abort_r <= 1'b1;
   end

   // Protection, evaluated combinationally so gating is immediate
   assign emu_protect = wait_r[FPV_BIT_OVHI] ^ wait_r[FPV_BIT_OVLO];
   assign sw_blocked = emu_protect || abort_r || clr_regs;
   assign blk_all = {blk2_r, blk1_r[3:0] & FPV_BLK1_MASK[3:0]};
   assign any_arm = ctrl_r[FPV_BIT_WRARM] || ctrl_r[FPV_BIT_SCARM];

   always_comb
   begin
      mode = FPV_MODE_IDLE;
      if (ctrl_r[FPV_BIT_WRARM])
         mode = FPV_MODE_PROG;
      else if (ctrl_r[FPV_BIT_SCARM])
         mode = FPV_MODE_ERASE;
      else if (ctrl_r[FPV_BIT_WRCHK] || ctrl_r[FPV_BIT_SCCHK])
         mode = FPV_MODE_VERIFY;
      else if (hv_ok)
         mode = FPV_MODE_PREVF;
   end

   // Verify-settle counter, restarted on each entry to prewrite-verify
   always_comb
   begin
      tvs_cnt_nxt = tvs_cnt_r;
      if (mode != FPV_MODE_PREVF)
         tvs_cnt_nxt = '0;
      else if (tvs_cnt_r != FPV_TVS_CYC[FPV_TVS_W-1:0])
         tvs_cnt_nxt = tvs_cnt_r + 1'b1;
   end

   always_ff @(posedge mclk or negedge rst_int_n)
   begin
      if (!rst_int_n)
         tvs_cnt_r <= '0;
      else
         tvs_cnt_r <= tvs_cnt_nxt;
   end

   always_comb
   begin
      flash_ctl.prog_en = (mode == FPV_MODE_PROG) && !sw_blocked && (blk_all != 12'h000);
      flash_ctl.erase_en = (mode == FPV_MODE_ERASE) && !sw_blocked && (blk_all != 12'h000);
      flash_ctl.verify_en = (mode == FPV_MODE_VERIFY) && !clr_regs;
      flash_ctl.prevf_en = (mode == FPV_MODE_PREVF) && !clr_regs;
      flash_ctl.prevf_ready = flash_ctl.prevf_en && (tvs_cnt_r == FPV_TVS_CYC[FPV_TVS_W-1:0]);
      flash_ctl.read_unreliable = any_arm;
      flash_ctl.blk_en = (sw_blocked || !any_arm) ? 12'h000 : blk_all;
   end

   // Vector overlay: both bits, 12 V and an interrupt or an armed program/erase
   assign ovl_on = wait_r[FPV_BIT_OVHI] && wait_r[FPV_BIT_OVLO] && hv_ok &&
                   (irq_eff || nmi_s || any_arm);
   always_comb
   begin
      ovl.overlay_on = ovl_on;
      ovl.overlay_sel = {wait_r[FPV_BIT_OVHI], wait_r[FPV_BIT_OVLO]};
      ovl.irq_masked = cond_r[FPV_BIT_MASK];
      ovl.irq_latched = abort_r;
      mapped_addr = cpu_addr;
      if (ovl_on && (cpu_addr <= FPV_ROM_WIN_END))
         mapped_addr = FPV_RAM_WIN_BASE | cpu_addr;
   end

   // Read data
   always_comb
   begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
         FPV_OFS_CTRL: prdata_nxt[7:0] = ctrl_r;
         FPV_OFS_BLK1: prdata_nxt[7:0] = blk1_r;
         FPV_OFS_BLK2: prdata_nxt[7:0] = blk2_r;
         FPV_OFS_WAIT: prdata_nxt[7:0] = wait_r;
         FPV_OFS_COND: prdata_nxt[7:0] = cond_r;
         FPV_OFS_STAT: prdata_nxt[7:0] = {2'b00, mode != FPV_MODE_IDLE, flash_ctl.prevf_ready,
                                          ovl_on, hv_ok, emu_protect, abort_r};
         default: prdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_int_n)
   begin
      if (!rst_int_n)
         prdata <= 32'h0000_0000;
      else if (rd_en)
         prdata <= prdata_nxt;
   end
endmodule // fpv_flash_protect_verify_ctrl

// file: bench/fpv_flash_protect_verify_ctrl_props.sv
/* Port checker for the flash protect/verify controller.
   Sees only top-level ports; bound to every instance below. */
`timescale 1ns/1ns
module fpv_props
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wdt_rst,
   input wire logic standby_pin,
   input wire logic hv_supply_pin,
   input wire logic [15:0] cpu_addr,
   input wire fpv_pkg::fpv_flash_ctl_type flash_ctl,
   input wire fpv_pkg::fpv_ovl_type ovl,
   input wire logic [15:0] mapped_addr,
   input wire logic irq_to_cpu
);
   import fpv_pkg::*;
   wire pe = flash_ctl.prog_en | flash_ctl.erase_en;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Four samples leave room for the two-flop pin synchroniser
   property p_hv; !hv_supply_pin [*4] |-> !(pe | flash_ctl.verify_en); endproperty
   a_hv: assert property (p_hv) else $error("enabled without supply");
   property p_wdt; wdt_rst |=> !(pe | flash_ctl.verify_en); endproperty
   a_wdt: assert property (p_wdt) else $error("enabled after watchdog reset");
   property p_stby; standby_pin [*4] |-> !(pe | flash_ctl.verify_en); endproperty
   a_stby: assert property (p_stby) else $error("enabled in standby");
   property p_blk; flash_ctl.blk_en == 12'h000 |-> !pe; endproperty
   a_blk: assert property (p_blk) else $error("enabled with no block selected");
   property p_emu; ^ovl.overlay_sel |-> !pe; endproperty
   a_emu: assert property (p_emu) else $error("enabled with one overlay bit");
   property p_abort; ovl.irq_latched |-> !pe; endproperty
   a_abort: assert property (p_abort) else $error("enabled after abort");
   property p_hold; ovl.irq_latched && !wdt_rst && !standby_pin |=> ovl.irq_latched; endproperty
   a_hold: assert property (p_hold) else $error("abort latch lost");
   property p_map; 1'b1 |-> mapped_addr == ((ovl.overlay_on && cpu_addr <= 16'h007F) ?
      (16'hFC00 | cpu_addr) : cpu_addr); endproperty
   a_map: assert property (p_map) else $error("bad mapped address");
   property p_mask; ovl.irq_masked |-> !irq_to_cpu; endproperty
   a_mask: assert property (p_mask) else $error("masked interrupt passed");
endmodule // fpv_props

bind fpv_flash_protect_verify_ctrl fpv_props u_props (.mclk, .rst_n, .wdt_rst, .standby_pin,
   .hv_supply_pin, .cpu_addr, .flash_ctl, .ovl, .mapped_addr, .irq_to_cpu);

// file: bench/tb.sv
/* Self-checking bench for the flash protect/verify controller.
   Drives APB and the pins itself; no partner model. */
`timescale 1ns/1ns
module tb;
   import fpv_pkg::*;
   logic mclk = 0, rst_n = 0, wdt_rst = 0, standby_pin = 0, hv_supply_pin = 1, boot_mode = 0;
   logic irq_pin = 0, nmi_pin = 0, psel = 0, penable = 0, pwrite = 0;
   logic pready, pslverr, irq_to_cpu, nmi_to_cpu, e;
   logic [15:0] cpu_addr = 16'h0006, mapped_addr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic [3:0] pstrb = 4'hF;
   logic [2:0] pat [3] = '{3'b000, 3'b011, 3'b101};
   fpv_flash_ctl_type flash_ctl;
   fpv_ovl_type ovl;
   int fail_count = 0, cmp_count = 0;
   always #5 mclk = ~mclk;
   fpv_flash_protect_verify_ctrl uut (.mclk, .rst_n, .wdt_rst, .standby_pin, .hv_supply_pin,
      .boot_mode, .irq_pin, .nmi_pin, .cpu_addr, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .flash_ctl, .ovl, .mapped_addr, .irq_to_cpu, .nmi_to_cpu);
   task report_and_stop;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      @(posedge mclk);
      // Only pready ends the access phase; the watchdog bounds a hang
      while (pready !== 1'b1)
         @(posedge mclk);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge mclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1, a, d);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(0, a, 0);
      chk(q, x);
   endtask
   task do_reset;
      rst_n <= 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1;
      repeat (6) @(posedge mclk);
   endtask
   task t_reg;
      rd(FPV_OFS_CTRL, FPV_RST_CTRL);
      rd(FPV_OFS_BLK1, FPV_RST_BLK1);
      rd(FPV_OFS_BLK2, FPV_RST_BLK2);
      rd(FPV_OFS_WAIT, FPV_RST_WAIT);
      chk(e, 0);
      rd(8'h18, 0);
      chk(e, 1);
      chk(flash_ctl.prevf_en, 1);
      chk(flash_ctl.prevf_ready, 0);
      repeat (400) @(posedge mclk);
      chk(flash_ctl.prevf_ready, 1);
      wr(FPV_OFS_WAIT, 32'h88);
      chk(ovl.overlay_sel, 2'b10);
      // Lane 0 strobe low: the write must be dropped
      pstrb <= 4'hE;
      wr(FPV_OFS_WAIT, 32'h00);
      pstrb <= 4'hF;
      rd(FPV_OFS_WAIT, 32'h88);
      $display("t_reg done");
   endtask
   task t_blk;
      wr(FPV_OFS_BLK1, 32'hF0);
      wr(FPV_OFS_CTRL, 32'h01);
      chk(flash_ctl.prog_en, 0);
      wr(FPV_OFS_WAIT, 32'h08);
      chk(flash_ctl.prog_en, 0);
      wr(FPV_OFS_CTRL, 32'h04);
      chk(flash_ctl.verify_en, 1);
      chk(flash_ctl.read_unreliable, 0);
      wr(FPV_OFS_BLK2, 32'h01);
      wr(FPV_OFS_CTRL, 32'h02);
      chk(flash_ctl.blk_en, 12'h010);
      chk(flash_ctl.erase_en, 1);
      chk(flash_ctl.read_unreliable, 1);
      wr(FPV_OFS_WAIT, 32'h48);
      chk(flash_ctl.erase_en, 0);
      wr(FPV_OFS_CTRL, 32'h08);
      chk(flash_ctl.verify_en, 1);
      $display("t_blk done");
   endtask
   task t_irq;
      wr(FPV_OFS_WAIT, 32'hC8);
      wr(FPV_OFS_CTRL, 32'h01);
      chk(flash_ctl.prog_en, 1);
      chk(ovl.overlay_on, 1);
      chk(mapped_addr, 16'hFC06);
      cpu_addr <= 16'h0080;
      @(posedge mclk);
      chk(mapped_addr, 16'h0080);
      cpu_addr <= 16'h0006;
      irq_pin <= 1;
      repeat (4) @(posedge mclk);
      irq_pin <= 0;
      repeat (2) @(posedge mclk);
      chk(flash_ctl.prog_en, 0);
      rd(FPV_OFS_CTRL, 32'h01);
      rd(FPV_OFS_BLK2, 32'h01);
      rd(FPV_OFS_STAT, 32'h2D);
      wr(FPV_OFS_CTRL, 32'h00);
      wr(FPV_OFS_CTRL, 32'h01);
      chk(flash_ctl.prog_en, 0);
      wr(FPV_OFS_CTRL, 32'h04);
      chk(flash_ctl.verify_en, 1);
      do_reset;
      chk(ovl.irq_latched, 0);
      $display("t_irq done");
   endtask
   // Masked interrupt must not abort an armed program; the non-maskable one must
   task t_mask;
      wr(FPV_OFS_COND, 32'h80);
      wr(FPV_OFS_BLK2, 32'h01);
      wr(FPV_OFS_CTRL, 32'h01);
      irq_pin <= 1;
      repeat (4) @(posedge mclk);
      chk(irq_to_cpu, 0);
      chk(ovl.irq_masked, 1);
      chk(ovl.irq_latched, 0);
      nmi_pin <= 1;
      repeat (4) @(posedge mclk);
      chk(nmi_to_cpu, 1);
      chk(ovl.irq_latched, 1);
      wr(FPV_OFS_COND, 32'h00);
      chk(irq_to_cpu, 1);
      irq_pin <= 0;
      nmi_pin <= 0;
      do_reset;
      $display("t_mask done");
   endtask
   // Supply loss, watchdog reset and standby in turn
   task t_hw;
      for (int i = 0; i < 3; i++)
      begin
         wr(FPV_OFS_BLK2, 32'h01);
         wr(FPV_OFS_CTRL, 32'h01);
         chk(flash_ctl.prog_en, 1);
         {standby_pin, wdt_rst, hv_supply_pin} <= pat[i];
         repeat (4) @(posedge mclk);
         chk(flash_ctl.prog_en, 0);
         {standby_pin, wdt_rst, hv_supply_pin} <= 3'b001;
         repeat (4) @(posedge mclk);
         rd(FPV_OFS_CTRL, 0);
         rd(FPV_OFS_BLK2, 0);
      end
      $display("t_hw done");
   endtask
   task t_boot;
      boot_mode <= 1;
      do_reset;
      rd(FPV_OFS_WAIT, FPV_BOOT_WAIT);
      rd(FPV_OFS_COND, FPV_BOOT_COND);
      boot_mode <= 0;
      irq_pin <= 1;
      nmi_pin <= 1;
      repeat (4) @(posedge mclk);
      chk(irq_to_cpu, 0);
      chk(nmi_to_cpu, 1);
      chk(mapped_addr, 16'hFC06);
      irq_pin <= 0;
      nmi_pin <= 0;
      repeat (4) @(posedge mclk);
      wr(FPV_OFS_WAIT, 32'h08);
      chk(ovl.overlay_sel, 2'b00);
      $display("t_boot done");
   endtask
   initial
   begin
      do_reset;
      t_reg;
      t_blk;
      t_irq;
      t_mask;
      t_hw;
      t_boot;
      report_and_stop;
   end
   // Several times the expected run of under two thousand cycles
   initial
   begin
      #100000;
      fail_count++;
      report_and_stop;
   end
endmodule // tb
